// [design/mdc_defs.vh]
// constants for the modem terminal-side control line block
// assumes a 50 MHz core clock; included by the control line logic
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

// operating modes
`define MDC_MODE_ASYNC       2'h0
`define MDC_MODE_ECM         2'h1
`define MDC_MODE_SYNC        2'h2

// transmit clock sources
`define MDC_TXC_INTERNAL     2'h0
`define MDC_TXC_RECOVERED    2'h1
`define MDC_TXC_TERMINAL     2'h2

// terminal-ready reactions
`define MDC_DTR_IGNORE       2'h0
`define MDC_DTR_CMD          2'h1
`define MDC_DTR_HANGUP       2'h2
`define MDC_DTR_RESET        2'h3

// clear-to-send delay unit and its cycle count at the core clock
`define MDC_CLK_MHZ          50
`define MDC_CTS_UNIT_US      10
`define MDC_CTS_UNIT_CYC     (`MDC_CTS_UNIT_US * `MDC_CLK_MHZ)

// default internal transmit clock divider (half period in core cycles)
`define MDC_INT_HALF_DIV     16'h0005

// reset values
`define MDC_RST_LOW          1'b0

`endif

// [design/mdc_sync2.v]
// two-flop synchroniser for a bundle of asynchronous level inputs
// assumes inputs come from pins or another clock; output is on i_core_clk
`timescale 1ns/1ps
module mdc_sync2 #(
  parameter W = 1
) (
  input  wire         i_core_clk,
  input  wire         i_arst_n,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta_q;

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// [design/mdc_ctrl_lines.v]
// control lines and bit clocks of the modem serial port toward the terminal
// assumes configuration is static and set by the command layer; terminal pins,
// line status and clocks from the data pump are asynchronous and synchronised here
`timescale 1ns/1ps
`include "mdc_defs.vh"
module mdc_ctrl_lines #(
  parameter DLY_W = 8
) (
  input  wire             i_core_clk,
  input  wire             i_arst_n,
  // configuration from the command layer
  input  wire [1:0]       i_cfg_mode,
  input  wire             i_cfg_hw_flow,
  input  wire             i_cfg_sync_rts_cts,
  input  wire [DLY_W-1:0] i_cfg_cts_delay,
  input  wire [1:0]       i_cfg_txc_src,
  input  wire             i_cfg_dsr_force,
  input  wire             i_cfg_dcd_force,
  input  wire             i_cfg_sync_frame_mode,
  input  wire [1:0]       i_cfg_dtr_action,
  input  wire [15:0]      i_cfg_int_half_div,
  // modem state
  input  wire             i_cmd_state,
  input  wire             i_off_hook,
  input  wire             i_test_mode,
  input  wire             i_carrier_ok,
  input  wire             i_sync_ready,
  input  wire             i_ring_det,
  input  wire             i_frame_end,
  input  wire             i_rate_alt,
  input  wire             i_rx_space_ok,
  input  wire             i_rx_data_avail,
  input  wire             i_rx_carrier_clk,
  // terminal pins
  input  wire             i_rts,
  input  wire             i_dtr,
  input  wire             i_term_txc,
  // outputs to the terminal
  output reg              o_cts,
  output reg              o_dsr,
  output reg              o_dcd,
  output reg              o_ri,
  output reg              o_rate_sel_a,
  output reg              o_rate_sel_b,
  output reg              o_txc,
  output reg              o_rxc,
  // outputs to the modem core
  output reg              o_rx_deliver_en,
  output reg              o_dtr_hangup,
  output reg              o_dtr_to_cmd,
  output reg              o_dtr_reset,
  output reg              o_sync_clk_sel
);

  localparam integer UNIT_CYC = `MDC_CTS_UNIT_CYC;

  // cts sequencing states (one-hot)
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_ON   = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  wire [5:0] pin_s;

  mdc_sync2 #(
    .W(6)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    ({i_rts, i_dtr, i_term_txc, i_rx_carrier_clk, i_carrier_ok, i_ring_det}),
    .o_sync     (pin_s)
  );

  wire rts_s    = pin_s[5];
  wire dtr_s    = pin_s[4];
  wire ttxc_s   = pin_s[3];
  wire rclk_s   = pin_s[2];
  wire carr_s   = pin_s[1];
  wire ring_s   = pin_s[0];

  // ==========================================================
  // configuration sampling
  // ==========================================================
  reg [1:0]       mode_q;
  reg             flow_q;
  reg             srts_q;
  reg [DLY_W-1:0] dly_q;
  reg [1:0]       txsrc_q;
  reg             dsrf_q;
  reg             dcdf_q;
  reg             frm_q;
  reg [1:0]       dtra_q;
  reg [15:0]      hdiv_q;

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q  <= `MDC_MODE_ASYNC;
      flow_q  <= `MDC_RST_LOW;
      srts_q  <= `MDC_RST_LOW;
      dly_q   <= {DLY_W{1'b0}};
      txsrc_q <= `MDC_TXC_INTERNAL;
      dsrf_q  <= `MDC_RST_LOW;
      dcdf_q  <= `MDC_RST_LOW;
      frm_q   <= `MDC_RST_LOW;
      dtra_q  <= `MDC_DTR_IGNORE;
      hdiv_q  <= `MDC_INT_HALF_DIV;
    end else begin
      mode_q  <= i_cfg_mode;
      flow_q  <= i_cfg_hw_flow;
      srts_q  <= i_cfg_sync_rts_cts;
      dly_q   <= i_cfg_cts_delay;
      txsrc_q <= i_cfg_txc_src;
      dsrf_q  <= i_cfg_dsr_force;
      dcdf_q  <= i_cfg_dcd_force;
      frm_q   <= i_cfg_sync_frame_mode;
      dtra_q  <= i_cfg_dtr_action;
      // a zero divider would wrap the compare to 16'hffff and slow the internal clock, so it is clamped to one
      hdiv_q  <= (i_cfg_int_half_div == 16'h0000) ? 16'h0001 : i_cfg_int_half_div;
    end
  end

  wire is_sync = (mode_q == `MDC_MODE_SYNC);
  wire is_ecm  = (mode_q == `MDC_MODE_ECM);

  // ==========================================================
  // status lines
  // ==========================================================
  wire dsr_real = i_off_hook & ~i_test_mode;
  wire dsr_nxt  = (~is_sync & dsrf_q) ? 1'b1 : dsr_real;
  wire dcd_nxt  = (~is_sync & dcdf_q) ? 1'b1 : carr_s;

  // ==========================================================
  // request-to-send edge and cts delay
  // ==========================================================
  reg        rts_d_q;
  reg [3:0]  st_q;
  reg [3:0]  st_d;
  reg [DLY_W-1:0] dcnt_q;
  reg [15:0] ucnt_q;
  reg        hook_q;

  wire rts_rise  = rts_s & ~rts_d_q;
  // a short hook flash leaves st_q on for one more edge; go_hook pulls cts down then
  wire go_hook   = i_off_hook & ~hook_q;
  wire sync_live = is_sync & ~i_cmd_state;
  wire sync_rdy  = o_dsr & o_dcd & i_sync_ready;
  wire dly_done  = (dcnt_q == {DLY_W{1'b0}});

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (sync_live & sync_rdy & (~srts_q | rts_rise))
          st_d = (srts_q & ~dly_done) ? ST_WAIT : ST_ON;
      end
      ST_WAIT: begin
        if (dly_done)
          st_d = ST_ON;
      end
      ST_ON: begin
        st_d = ST_ON;
      end
      ST_HOLD: begin
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    // leaving sync, command state, losing readiness, going off hook or dropping rts with rts/cts enabled restarts
    if (~sync_live | ~sync_rdy | go_hook | (srts_q & ~rts_s))
      st_d = ST_IDLE;
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q    <= ST_IDLE;
      rts_d_q <= `MDC_RST_LOW;
      hook_q  <= `MDC_RST_LOW;
      dcnt_q  <= {DLY_W{1'b0}};
      ucnt_q  <= 16'h0000;
    end else begin
      st_q    <= st_d;
      rts_d_q <= rts_s;
      hook_q  <= i_off_hook;
      if (st_q != ST_WAIT) begin
        dcnt_q <= dly_q;
        ucnt_q <= 16'h0000;
      end else if (ucnt_q == UNIT_CYC[15:0] - 16'h0001) begin
        ucnt_q <= 16'h0000;
        dcnt_q <= dcnt_q - {{(DLY_W-1){1'b0}}, 1'b1};
      end else begin
        ucnt_q <= ucnt_q + 16'h0001;
      end
    end
  end

  // cts by mode
  reg cts_nxt;
  always @* begin
    if (is_sync & i_cmd_state)
      cts_nxt = 1'b1;
    else if (is_sync)
      cts_nxt = (st_q == ST_ON) & ~go_hook;
    else if (is_ecm & flow_q & ~i_cmd_state)
      cts_nxt = i_rx_space_ok;
    else
      cts_nxt = 1'b1;
  end

  // delivery pause: rts only matters in ecm with flow control, on line
  wire deliver_nxt = (is_ecm & flow_q & ~i_cmd_state) ?
                     (rts_s & i_rx_data_avail) : i_rx_data_avail;

  // ==========================================================
  // bit clocks
  // ==========================================================
  reg [15:0] idiv_q;
  reg        iclk_q;

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idiv_q <= 16'h0000;
      iclk_q <= `MDC_RST_LOW;
    end else if (idiv_q >= hdiv_q - 16'h0001) begin
      idiv_q <= 16'h0000;
      iclk_q <= ~iclk_q;
    end else begin
      idiv_q <= idiv_q + 16'h0001;
    end
  end

  reg txc_nxt;
  always @* begin
    case (txsrc_q)
      `MDC_TXC_RECOVERED: txc_nxt = rclk_s;
      `MDC_TXC_TERMINAL:  txc_nxt = is_sync ? ttxc_s : iclk_q;
      default:            txc_nxt = iclk_q;
    endcase
  end

  // ==========================================================
  // output registers
  // ==========================================================
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cts           <= `MDC_RST_LOW;
      o_dsr           <= `MDC_RST_LOW;
      o_dcd           <= `MDC_RST_LOW;
      o_ri            <= `MDC_RST_LOW;
      o_rate_sel_a    <= `MDC_RST_LOW;
      o_rate_sel_b    <= `MDC_RST_LOW;
      o_txc           <= `MDC_RST_LOW;
      o_rxc           <= `MDC_RST_LOW;
      o_rx_deliver_en <= `MDC_RST_LOW;
      o_dtr_hangup    <= `MDC_RST_LOW;
      o_dtr_to_cmd    <= `MDC_RST_LOW;
      o_dtr_reset     <= `MDC_RST_LOW;
      o_sync_clk_sel  <= `MDC_RST_LOW;
    end else begin
      o_cts           <= cts_nxt;
      o_dsr           <= dsr_nxt;
      o_dcd           <= dcd_nxt;
      o_ri            <= frm_q ? i_frame_end : ring_s;
      o_rate_sel_a    <= ~i_rate_alt;
      o_rate_sel_b    <= i_rate_alt;
      o_txc           <= txc_nxt;
      // rxc is the recovered carrier clock, delayed by the synchroniser and this output register
      o_rxc           <= rclk_s;
      o_rx_deliver_en <= deliver_nxt;
      // terminal-ready drop: one level per configured reaction
      o_dtr_to_cmd    <= ~dtr_s & (dtra_q == `MDC_DTR_CMD);
      o_dtr_hangup    <= ~dtr_s & (dtra_q == `MDC_DTR_HANGUP);
      o_dtr_reset     <= ~dtr_s & (dtra_q == `MDC_DTR_RESET);
      o_sync_clk_sel  <= is_sync & (txsrc_q == `MDC_TXC_TERMINAL);
    end
  end

endmodule

// [test/mdc_ctrl_lines_assertions.sv]
// checker for the modem control line block
// assumes it is bound into mdc_ctrl_lines and sees only its ports
`timescale 1ns/1ps
module mdc_ctrl_lines_chk (
  input wire       i_core_clk,
  input wire       i_arst_n,
  input wire [1:0] i_cfg_mode,
  input wire       i_cfg_hw_flow,
  input wire [1:0] i_cfg_dtr_action,
  input wire       i_cfg_sync_frame_mode,
  input wire       i_cmd_state,
  input wire       i_off_hook,
  input wire       i_test_mode,
  input wire       i_carrier_ok,
  input wire       i_ring_det,
  input wire       i_frame_end,
  input wire       i_rate_alt,
  input wire       i_rx_space_ok,
  input wire       i_rx_carrier_clk,
  input wire       i_rts,
  input wire       i_dtr,
  input wire       o_cts,
  input wire       o_dsr,
  input wire       o_dcd,
  input wire       o_ri,
  input wire       o_rate_sel_a,
  input wire       o_rate_sel_b,
  input wire       o_rxc,
  input wire       o_rx_deliver_en,
  input wire       o_dtr_hangup
);
  // ======
  // properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  wire syn = (i_cfg_mode == 2'h2);
  wire asy = (i_cfg_mode == 2'h0);
  wire flw = (i_cfg_mode == 2'h1) && i_cfg_hw_flow && !i_cmd_state;
  chk_rate_sel_onehot: assert property ($past(i_arst_n) |->
    o_rate_sel_b == $past(i_rate_alt) && o_rate_sel_a != o_rate_sel_b) else $error("rate sel");
  chk_cts_async_on: assert property ((asy && !i_cfg_hw_flow)[*4] |-> o_cts)
    else $error("cts async");
  chk_cts_flow_off: assert property ((flw && !i_rx_space_ok)[*4] |-> !o_cts)
    else $error("cts flow");
  chk_deliver_pause: assert property ((flw && !i_rts)[*6] |-> !o_rx_deliver_en)
    else $error("deliver");
  chk_cts_sync_cmd: assert property ((syn && i_cmd_state)[*4] |-> o_cts)
    else $error("cts cmd");
  chk_cts_hook_drop: assert property ((syn && !i_cmd_state)[*3] ##0 $rose(i_off_hook)
    |-> ##1 !o_cts) else $error("cts hook");
  chk_dsr_test_off: assert property ((syn && i_test_mode)[*4] |-> !o_dsr)
    else $error("dsr test");
  chk_dcd_sync_track: assert property ((syn && !i_carrier_ok)[*6] |-> !o_dcd)
    else $error("dcd sync");
  chk_ri_ring_on: assert property ((!i_cfg_sync_frame_mode && i_ring_det)[*5] |-> o_ri)
    else $error("ri ring");
  chk_ri_frame_mask: assert property ((i_cfg_sync_frame_mode && !i_frame_end)[*4] |-> !o_ri)
    else $error("ri frame");
  chk_rxc_follow: assert property ($rose(i_rx_carrier_clk) |-> ##[2:4] o_rxc)
    else $error("rxc");
  chk_dtr_hangup_on: assert property ((i_cfg_dtr_action == 2'h2 && !i_dtr)[*6]
    |-> o_dtr_hangup) else $error("hangup");
  cover property (syn && $rose(o_cts));
  cover property ($rose(o_ri));
  cover property ($rose(o_dtr_hangup));
endmodule

// [test/mdc_dte_model.sv]
// terminal side model: handshake pins, transmit clock and data
// assumes the bench asks for sending and for terminal-ready by its inputs
`timescale 1ns/1ps
module mdc_dte_model (
  input  wire i_req_tx,
  input  wire i_dtr_on,
  input  wire i_cts,
  input  wire i_dsr,
  input  wire i_txc,
  output wire o_rts,
  output wire o_dtr,
  output reg  o_term_txc,
  output reg  o_txd
);
  // ======
  // terminal behaviour
  reg [7:0] pat_q = 8'h5a;
  assign o_rts = i_req_tx;
  assign o_dtr = i_dtr_on;
  initial o_term_txc = 1'h0;
  // own clock stands still unless sending
  always #80 o_term_txc = i_req_tx & ~o_term_txc;
  always @(negedge i_txc) begin
    o_txd <= (o_rts & i_cts & i_dsr & o_dtr) ? pat_q[0] : 1'h1;
    pat_q <= {pat_q[0], pat_q[7:1]};
  end
endmodule

// [test/tb_mdc_ctrl_lines.sv]
// testbench for the modem control line block
// assumes the terminal model and the checker are compiled alongside
`timescale 1ns/1ps
module tb_mdc_ctrl_lines;
  // ======
  // signals
  logic i_core_clk = 0, i_arst_n = 0, req = 0, dtr_on = 1;
  logic [1:0] i_cfg_mode = 0, i_cfg_txc_src = 0, i_cfg_dtr_action = 0;
  logic [7:0] i_cfg_cts_delay = 8'h01;
  logic [15:0] i_cfg_int_half_div = 16'h0005;
  logic i_cfg_hw_flow = 0, i_cfg_sync_rts_cts = 0, i_cfg_dsr_force = 0, i_cfg_dcd_force = 0;
  logic i_cfg_sync_frame_mode = 0, i_cmd_state = 0, i_off_hook = 0, i_test_mode = 0;
  logic i_carrier_ok = 0, i_sync_ready = 0, i_ring_det = 0, i_frame_end = 0, i_rate_alt = 0;
  logic i_rx_space_ok = 0, i_rx_data_avail = 0, i_rx_carrier_clk = 0;
  wire i_rts, i_dtr, i_term_txc, o_cts, o_dsr, o_dcd, o_ri, o_rate_sel_a, o_rate_sel_b;
  wire o_txc, o_rxc, o_rx_deliver_en, o_dtr_hangup, o_dtr_to_cmd, o_dtr_reset, o_sync_clk_sel;
  int bad_count = 0, total_checks = 0, n;
  mdc_ctrl_lines #(.DLY_W(8)) dut (.*);
  mdc_dte_model term (.i_req_tx(req), .i_dtr_on(dtr_on), .i_cts(o_cts), .i_dsr(o_dsr),
    .i_txc(o_txc), .o_rts(i_rts), .o_dtr(i_dtr), .o_term_txc(i_term_txc), .o_txd());
  always #10 i_core_clk = ~i_core_clk;
  always #80 i_rx_carrier_clk = ~i_rx_carrier_clk;
  // ======
  // helpers
  task w(input int c);
    repeat (c) @(posedge i_core_clk);
  endtask
  task chk(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %b exp %b", $time, g, e);
    end
  endtask
  task chkn(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %0t count %0d", $time, g);
    end
  endtask
  task per(output int c);
    time t0;
    @(posedge o_txc);
    t0 = $time;
    @(posedge o_txc);
    c = int'(($time - t0) / 20);
  endtask
  task print_verdict;
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ======
  // scenarios
  task t_async;
    i_cfg_dsr_force <= 1; i_cfg_dcd_force <= 1; i_rate_alt <= 1; w(6);
    chk(o_cts, 1);
    chk(o_dsr, 1);
    chk(o_dcd, 1);
    chk(o_rate_sel_b, 1);
    i_cfg_dsr_force <= 0; i_cfg_dcd_force <= 0; i_rate_alt <= 0; req <= 1; w(6);
    chk(o_cts, 1);
    chk(o_dsr, 0);
    chk(o_dcd, 0);
    chk(o_rate_sel_a, 1);
    i_off_hook <= 1; i_carrier_ok <= 1; w(6);
    chk(o_dsr, 1);
    chk(o_dcd, 1);
  endtask
  task t_ecm;
    i_cfg_mode <= 2'h1; i_cfg_hw_flow <= 1; i_rx_data_avail <= 1; req <= 0; w(6);
    chk(o_cts, 0);
    chk(o_rx_deliver_en, 0);
    i_rx_space_ok <= 1; req <= 1; w(6);
    chk(o_cts, 1);
    chk(o_rx_deliver_en, 1);
  endtask
  task t_sync;
    i_cfg_mode <= 2'h2; i_cfg_hw_flow <= 0; i_cfg_sync_rts_cts <= 1; i_cfg_dcd_force <= 1;
    i_sync_ready <= 1; req <= 0; w(8);
    chk(o_cts, 0);
    req <= 1; n = 0;
    do begin w(1); n++; end while (o_cts !== 1'b1 && n < 800);
    chkn(n, 500, 510);
    req <= 0; w(6);
    chk(o_cts, 0);
    i_cfg_sync_rts_cts <= 0; i_carrier_ok <= 0; w(8);
    chk(o_dcd, 0);
    chk(o_cts, 0);
    i_cmd_state <= 1; w(6);
    chk(o_cts, 1);
    i_cmd_state <= 0; i_carrier_ok <= 1; i_test_mode <= 1; w(8);
    chk(o_dsr, 0);
    chk(o_cts, 0);
    i_test_mode <= 0; w(8);
    chk(o_cts, 1);
    i_off_hook <= 0;
    w(1);
    i_off_hook <= 1;
    w(2);
    chk(o_cts, 0);
  endtask
  task t_ring;
    i_ring_det <= 1; w(6);
    chk(o_ri, 1);
    i_cfg_sync_frame_mode <= 1; w(6);
    chk(o_ri, 0);
    i_frame_end <= 1; w(3);
    chk(o_ri, 1);
    i_frame_end <= 0; i_ring_det <= 0; i_cfg_sync_frame_mode <= 0; w(6);
  endtask
  task t_dtr;
    for (int a = 0; a < 4; a++) begin
      i_cfg_dtr_action <= a[1:0]; dtr_on <= 0; w(6);
      chk(o_dtr_to_cmd, a == 1);
      chk(o_dtr_hangup, a == 2);
      chk(o_dtr_reset, a == 3);
      dtr_on <= 1; w(6);
    end
  endtask
  task t_clk;
    i_cfg_mode <= 2'h0; i_cfg_txc_src <= 2'h2; req <= 1; w(6);
    per(n);
    chkn(n, 10, 10);
    chk(o_sync_clk_sel, 0);
    w(1); i_cfg_mode <= 2'h2; w(12);
    per(n);
    chkn(n, 7, 9);
    chk(o_sync_clk_sel, 1);
    w(1);
    i_cfg_txc_src <= 2'h1;
    w(12);
    per(n);
    chkn(n, 8, 8);
    w(1);
    chk(o_rxc, 1);
    w(4);
    chk(o_rxc, 0);
  endtask
  initial begin
    w(4); i_arst_n <= 1; w(4);
    t_async; t_ecm; t_sync; t_ring; t_dtr; t_clk;
    print_verdict;
  end
  initial begin
    #200us;
    bad_count++;
    $display("[ERR] %0t timeout", $time);
    print_verdict;
  end
endmodule
bind mdc_ctrl_lines mdc_ctrl_lines_chk u_chk (.*);
